// *** pbr_llc_model.sv ***
// Link controller model: APB master that reaches the register bank
`timescale 1ns/1ns
`default_nettype none
module pbr_llc_model (
    input  wire logic        clk,
    output logic             psel    = 1'b0,
    output logic             penable = 1'b0,
    output logic             pwrite  = 1'b0,
    output logic [7:0]       paddr   = 8'h00,
    output logic [31:0]      pwdata  = 32'h0,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // --------------------------------
    // Bus cycle
    // --------------------------------
    // Request held until pready is seen; the bench timeout ends a hang
    // Model claims supplement support, so it may set accel_arb_enable
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** pbr_pkg.sv ***
// Package for the base control and status register bank of the bus physical layer
package pbr_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [3:0] PBR_IDX_LINK_CONTENDER_POWER = 4'h5;
    localparam logic [3:0] PBR_IDX_INTERRUPT_FEATURE    = 4'h6;
    localparam logic [3:0] PBR_IDX_PAGE_PORT_SELECT     = 4'h7;
    localparam logic [3:0] PBR_IDX_PORT_STATUS_A        = 4'h8;
    localparam logic [3:0] PBR_IDX_PORT_STATUS_B        = 4'h9;
    localparam int         PBR_ADDR_LSB                 = 2;
    localparam int         PBR_IDX_W                    = 4;

    // ------------------------------------------------------------------
    // Field positions, register 5
    // ------------------------------------------------------------------
    localparam int PBR_LINK_ACTIVE_CTRL_BIT  = 7;
    localparam int PBR_CONT_BIT   = 6;
    localparam int PBR_JIT_LSB    = 3;
    localparam int PBR_PCLASS_LSB = 0;

    // Field positions, register 6
    localparam int PBR_RESUME_IRQ_ENABLE_BIT  = 7;
    localparam int PBR_SHORT_RESET_REQUEST_BIT  = 6;
    localparam int PBR_CTO_BIT   = 5;
    localparam int PBR_CPS_BIT   = 4;
    localparam int PBR_STO_BIT   = 3;
    localparam int PBR_PEV_BIT   = 2;
    localparam int PBR_EAA_BIT   = 1;
    localparam int PBR_EMC_BIT   = 0;

    // Field positions, register 7
    localparam int PBR_PAGE_LSB  = 5;
    localparam int PBR_PORT_LSB  = 0;

    // Field positions, port status page
    localparam int PBR_DIS_BIT   = 0;
    localparam int PBR_PIE_BIT   = 4;
    localparam int PBR_FAULT_BIT = 3;

    // ------------------------------------------------------------------
    // Reset values and fixed read values
    // ------------------------------------------------------------------
    localparam logic       PBR_LINK_ACTIVE_CTRL_RST  = 1'b1;
    localparam logic       PBR_CABLE_POWER_IRQ_RST   = 1'b1;
    localparam logic [2:0] PBR_JITTER_VAL = 3'h0;
    localparam logic [2:0] PBR_PAGE_RST   = 3'h0;
    localparam logic [3:0] PBR_PORT_RST   = 4'h0;
    localparam logic [2:0] PBR_PAGE_PORT  = 3'h0;

    // Per-port status delivered by the port logic
    typedef struct packed {
        logic [1:0] astat;
        logic [1:0] bstat;
        logic       child;
        logic       con;
        logic       bias;
        logic [2:0] peer_speed;
    } pbr_port_stat_s;

endpackage

// *** pbr_regs.sv ***
// Base control/status registers of the bus physical layer, APB slave
// Summary of operation
// - Self-ID link-active bit is link_active_ctrl AND link_power_status.
// - link_active_ctrl is 1 after hardware reset, kept over bus reset.
// - Link interface runs solely on link_power_status, regardless of link_active_ctrl.
// - Contender bit goes to self-ID; reset loads contender_linkon_pin level.
// - Three-bit jitter field is read-only and reads zero.
// - node_power_class goes to self-ID power field; reset loads power_class_pins.
// - resume_irq_enable lets resume start set port_event_flag; cleared by hardware reset.
// - Writing 1 to short_reset_request requests short reset; clears on bus reset.
// - With a legacy node present, a short reset request becomes a long reset.
// - config_timeout_flag sets on tree-ID start timeout; hardware reset or write-1 clears.
// - Config timeout plus resume enable with link inactive drives contender_linkon_pin.
// - cable_power_irq sets on cable_power_sense fall; resets to 1; write-1 clears.
// - state_timeout_flag sets on state timeout, forces bus reset, drives linkon pin; the code drives it only with resume_irq_enable set and the link inactive.
// - port_event_flag sets on status changes of ports with port_irq_enable.
// - accel_arb_enable turns on accelerated arbitration and fly-by concatenation.
// - multispeed_concat_enable allows concatenated packets of differing speeds.
// - page_selector picks the page mapped on addresses 8 to 15; reset 0.
// - port_selector picks the per-port registers, ports from 0; reset 0.
// - Reserved registers and fields read as zero.
// - Page 0 shows the selected port's status; absent ports read zero.
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module pbr_regs
    import pbr_pkg::*;
#(
    parameter int NUM_PORTS = 3,
    parameter int ADDR_W    = 8
) (
    input  wire logic                   CLK,
    input  wire logic                   NRST,
    input  wire logic                   PSEL,
    input  wire logic                   PENABLE,
    input  wire logic                   PWRITE,
    input  wire logic [ADDR_W-1:0]      PADDR,
    input  wire logic [31:0]            PWDATA,
    input  wire logic [3:0]             PSTRB,
    output logic      [31:0]            PRDATA,
    output logic                        PREADY,
    output logic                        PSLVERR,
    input  wire logic                   LINK_POWER_STATUS,
    input  wire logic                   CONTENDER_LINKON_PIN_I,
    output logic                        CONTENDER_LINKON_PIN_O,
    output logic                        CONTENDER_LINKON_PIN_OE,
    input  wire logic [2:0]             POWER_CLASS_PINS,
    input  wire logic                   CABLE_POWER_SENSE,
    input  wire logic                   BUS_RESET_EVT,
    input  wire logic                   CONFIG_TIMEOUT_EVT,
    input  wire logic                   STATE_TIMEOUT_EVT,
    input  wire logic                   LEGACY_NODE_PRESENT,
    input  wire logic [NUM_PORTS-1:0]   RESUME_START_EVT,
    input  wire logic [NUM_PORTS-1:0]   PORT_FAULT_EVT,
    input  wire pbr_port_stat_s         PORT_STATUS [NUM_PORTS],
    output logic                        LINK_IF_ENABLE,
    output logic                        SELF_ID_LINK_ACTIVE,
    output logic                        SELF_ID_CONTENDER,
    output logic      [2:0]             SELF_ID_POWER_CLASS,
    output logic                        SHORT_RESET_REQ,
    output logic                        LONG_RESET_REQ,
    output logic                        ACCEL_ARB_EN,
    output logic                        MULTISPEED_CONCAT_EN,
    output logic      [NUM_PORTS-1:0]   PORT_DISABLE,
    output logic      [2:0]             PAGE_SEL,
    output logic      [3:0]             PORT_SEL
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic       lps_meta_reg,  lps_sync_reg;
    logic       clk_meta_reg,  clk_sync_reg;
    logic [2:0] pc_meta_reg,   pc_sync_reg;
    logic       cps_meta_reg,  cps_sync_reg, cps_prev_reg;

    // Two flops per pin; edge detect looks only at the second stage
    always_ff @(posedge CLK) begin
        lps_meta_reg <= LINK_POWER_STATUS;
        lps_sync_reg <= lps_meta_reg;
        clk_meta_reg <= CONTENDER_LINKON_PIN_I;
        clk_sync_reg <= clk_meta_reg;
        pc_meta_reg  <= POWER_CLASS_PINS;
        pc_sync_reg  <= pc_meta_reg;
        cps_meta_reg <= CABLE_POWER_SENSE;
        cps_sync_reg <= cps_meta_reg;
        cps_prev_reg <= cps_sync_reg;
    end

    logic cps_fall;
    assign cps_fall = cps_prev_reg & ~cps_sync_reg;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    logic [PBR_IDX_W-1:0] idx;
    logic                 in_range;
    logic                 wr_acc;
    logic                 setup;
    logic [7:0]           wdat;

    assign idx      = PADDR[PBR_ADDR_LSB +: PBR_IDX_W];
    assign in_range = (PADDR >> (PBR_ADDR_LSB + PBR_IDX_W)) == '0;
    assign setup    = PSEL & ~PENABLE;
    assign PREADY   = PSEL & PENABLE;
    // Writes land only at the completing edge, low byte lane only
    assign wr_acc   = PSEL & PENABLE & PWRITE & PSTRB[0] & in_range;
    assign wdat     = PWDATA[7:0];

    logic wr5, wr6, wr7, wr8, wr9;
    assign wr5 = wr_acc & (idx == PBR_IDX_LINK_CONTENDER_POWER);
    assign wr6 = wr_acc & (idx == PBR_IDX_INTERRUPT_FEATURE);
    assign wr7 = wr_acc & (idx == PBR_IDX_PAGE_PORT_SELECT);
    assign wr8 = wr_acc & (idx == PBR_IDX_PORT_STATUS_A);
    assign wr9 = wr_acc & (idx == PBR_IDX_PORT_STATUS_B);

    // ------------------------------------------------------------------
    // Register 5: link control, contender, power class
    // ------------------------------------------------------------------
    logic       link_active_ctrl_reg;
    logic       cont_reg;
    logic [2:0] pclass_reg;

    // Straps are sampled from the synchronised pins while reset is held
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            link_active_ctrl_reg  <= PBR_LINK_ACTIVE_CTRL_RST;
            cont_reg   <= clk_sync_reg;
            pclass_reg <= pc_sync_reg;
        end else if (wr5) begin
            link_active_ctrl_reg  <= wdat[PBR_LINK_ACTIVE_CTRL_BIT];
            cont_reg   <= wdat[PBR_CONT_BIT];
            pclass_reg <= wdat[PBR_PCLASS_LSB +: 3];
        end
    end

    // ------------------------------------------------------------------
    // Register 6: enables and sticky flags
    // ------------------------------------------------------------------
    logic resume_irq_enable_reg, short_reset_request_reg, cto_reg, cable_power_irq_reg, sto_reg, pev_reg;
    logic eaa_reg, emc_reg;

    // Plain enables survive bus reset
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            resume_irq_enable_reg <= 1'b0;
            eaa_reg  <= 1'b0;
            emc_reg  <= 1'b0;
        end else if (wr6) begin
            resume_irq_enable_reg <= wdat[PBR_RESUME_IRQ_ENABLE_BIT];
            eaa_reg  <= wdat[PBR_EAA_BIT];
            emc_reg  <= wdat[PBR_EMC_BIT];
        end
    end

    // Short reset request; a fresh write beats a coincident bus reset
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            short_reset_request_reg <= 1'b0;
        end else if (wr6 && wdat[PBR_SHORT_RESET_REQUEST_BIT]) begin
            short_reset_request_reg <= 1'b1;
        end else if (BUS_RESET_EVT) begin
            short_reset_request_reg <= 1'b0;
        end
    end

    // Port-event sources, built below
    logic pev_set;

    // Sticky flags: a hardware set wins over a write-one clear
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            cto_reg  <= 1'b0;
            cable_power_irq_reg <= PBR_CABLE_POWER_IRQ_RST;
            sto_reg  <= 1'b0;
            pev_reg  <= 1'b0;
        end else begin
            cto_reg  <= CONFIG_TIMEOUT_EVT | (cto_reg & ~(wr6 & wdat[PBR_CTO_BIT]));
            cable_power_irq_reg <= cps_fall | (cable_power_irq_reg & ~(wr6 & wdat[PBR_CPS_BIT]));
            sto_reg  <= STATE_TIMEOUT_EVT | (sto_reg & ~(wr6 & wdat[PBR_STO_BIT]));
            pev_reg  <= pev_set | (pev_reg & ~(wr6 & wdat[PBR_PEV_BIT]));
        end
    end

    // ------------------------------------------------------------------
    // Register 7: page and port selectors
    // ------------------------------------------------------------------
    logic [2:0] page_reg;
    logic [3:0] port_reg;

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            page_reg <= PBR_PAGE_RST;
            port_reg <= PBR_PORT_RST;
        end else if (wr7) begin
            page_reg <= wdat[PBR_PAGE_LSB +: 3];
            port_reg <= wdat[PBR_PORT_LSB +: 4];
        end
    end

    // ------------------------------------------------------------------
    // Per-port control and event detection
    // ------------------------------------------------------------------
    logic                 port_valid;
    logic                 page0;
    logic [NUM_PORTS-1:0] dis_reg, pie_reg, fault_reg;
    logic [NUM_PORTS-1:0] con_prev_reg, bias_prev_reg, dis_prev_reg, fault_prev_reg;
    logic [NUM_PORTS-1:0] port_chg;

    assign port_valid = 32'(port_reg) < NUM_PORTS;
    assign page0      = page_reg == PBR_PAGE_PORT;

    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++) begin : g_port
            logic hit;
            assign hit = page0 & (32'(port_reg) == g);

            // Disable and interrupt enable, kept over bus reset
            always_ff @(posedge CLK) begin
                if (!NRST) begin
                    dis_reg[g] <= 1'b0;
                    pie_reg[g] <= 1'b0;
                end else begin
                    if (wr8 && hit) begin
                        dis_reg[g] <= wdat[PBR_DIS_BIT];
                    end
                    if (wr9 && hit) begin
                        pie_reg[g] <= wdat[PBR_PIE_BIT];
                    end
                end
            end

            // Fault flag, write-one clear, event wins
            always_ff @(posedge CLK) begin
                if (!NRST) begin
                    fault_reg[g] <= 1'b0;
                end else begin
                    fault_reg[g] <= PORT_FAULT_EVT[g]
                                  | (fault_reg[g] & ~(wr9 & hit & wdat[PBR_FAULT_BIT]));
                end
            end

            // Previous values for change detection
            always_ff @(posedge CLK) begin
                if (!NRST) begin
                    con_prev_reg[g]   <= 1'b0;
                    bias_prev_reg[g]  <= 1'b0;
                    dis_prev_reg[g]   <= 1'b0;
                    fault_prev_reg[g] <= 1'b0;
                end else begin
                    con_prev_reg[g]   <= PORT_STATUS[g].con;
                    bias_prev_reg[g]  <= PORT_STATUS[g].bias;
                    dis_prev_reg[g]   <= dis_reg[g];
                    fault_prev_reg[g] <= fault_reg[g];
                end
            end

            // Change of any watched status bit on an enabled port
            assign port_chg[g] = pie_reg[g] & ((con_prev_reg[g] ^ PORT_STATUS[g].con)
                               | (bias_prev_reg[g] ^ PORT_STATUS[g].bias)
                               | (dis_prev_reg[g] ^ dis_reg[g])
                               | (fault_prev_reg[g] ^ fault_reg[g]));
        end
    endgenerate

    assign pev_set = (|port_chg) | (resume_irq_enable_reg & (|RESUME_START_EVT));

    // ------------------------------------------------------------------
    // Read mux, captured in the setup cycle
    // ------------------------------------------------------------------
    logic [7:0]     rd_byte;
    pbr_port_stat_s sel_stat;
    logic           sel_dis, sel_pie, sel_fault;

    // Unimplemented ports read as all zero
    always_comb begin
        sel_stat  = '0;
        sel_dis   = 1'b0;
        sel_pie   = 1'b0;
        sel_fault = 1'b0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (32'(port_reg) == p) begin
                sel_stat  = PORT_STATUS[p];
                sel_dis   = dis_reg[p];
                sel_pie   = pie_reg[p];
                sel_fault = fault_reg[p];
            end
        end
    end

    // Anything not listed, reserved bits included, reads zero
    always_comb begin
        rd_byte = 8'h00;
        unique case (idx)
            PBR_IDX_LINK_CONTENDER_POWER: begin
                rd_byte[PBR_LINK_ACTIVE_CTRL_BIT]       = link_active_ctrl_reg;
                rd_byte[PBR_CONT_BIT]        = cont_reg;
                rd_byte[PBR_JIT_LSB +: 3]    = PBR_JITTER_VAL;
                rd_byte[PBR_PCLASS_LSB +: 3] = pclass_reg;
            end
            PBR_IDX_INTERRUPT_FEATURE: begin
                rd_byte = {resume_irq_enable_reg, short_reset_request_reg, cto_reg, cable_power_irq_reg,
                           sto_reg, pev_reg, eaa_reg, emc_reg};
            end
            PBR_IDX_PAGE_PORT_SELECT: begin
                rd_byte[PBR_PAGE_LSB +: 3] = page_reg;
                rd_byte[PBR_PORT_LSB +: 4] = port_reg;
            end
            PBR_IDX_PORT_STATUS_A: begin
                if (page0 && port_valid) begin
                    rd_byte = {sel_stat.astat, sel_stat.bstat, sel_stat.child,
                               sel_stat.con, sel_stat.bias, sel_dis};
                end
            end
            PBR_IDX_PORT_STATUS_B: begin
                if (page0 && port_valid) begin
                    rd_byte = {sel_stat.peer_speed, sel_pie, sel_fault, 3'h0};
                end
            end
            default: rd_byte = 8'h00;
        endcase
    end

    // Data and error held from setup through the access phase
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (setup) begin
            PRDATA  <= in_range ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            PSLVERR <= ~in_range;
        end
    end

    // ------------------------------------------------------------------
    // Outputs toward the physical layer core
    // ------------------------------------------------------------------
    logic link_active;
    logic linkon_reg;
    logic long_pend_reg;

    assign link_active = link_active_ctrl_reg & lps_sync_reg;

    // Linkon stays driven while resume_irq_enable is set and an unserviced timeout waits on an idle link
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            linkon_reg <= 1'b0;
        end else begin
            linkon_reg <= ~link_active & resume_irq_enable_reg & (cto_reg | sto_reg);
        end
    end

    // A state timeout holds a bus reset request until the reset happens
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            long_pend_reg <= 1'b0;
        end else if (STATE_TIMEOUT_EVT) begin
            long_pend_reg <= 1'b1;
        end else if (BUS_RESET_EVT) begin
            long_pend_reg <= 1'b0;
        end
    end

    assign CONTENDER_LINKON_PIN_O  = linkon_reg;
    assign CONTENDER_LINKON_PIN_OE = linkon_reg;
    assign LINK_IF_ENABLE          = lps_sync_reg;
    assign SELF_ID_LINK_ACTIVE     = link_active;
    assign SELF_ID_CONTENDER       = cont_reg;
    assign SELF_ID_POWER_CLASS     = pclass_reg;
    // Legacy nodes cannot do short resets, so ask for a long one
    assign SHORT_RESET_REQ         = short_reset_request_reg & ~LEGACY_NODE_PRESENT;
    assign LONG_RESET_REQ          = long_pend_reg | (short_reset_request_reg & LEGACY_NODE_PRESENT);
    // Only meaningful when the link controller is supplement aware
    assign ACCEL_ARB_EN            = eaa_reg;
    assign MULTISPEED_CONCAT_EN    = emc_reg;
    assign PORT_DISABLE            = dis_reg;
    assign PAGE_SEL                = page_reg;
    assign PORT_SEL                = port_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_link_active_and: assert property (@(posedge CLK) disable iff (!NRST)
        SELF_ID_LINK_ACTIVE == (link_active_ctrl_reg & lps_sync_reg))
        else $error("link active bit differs from control and power status");

    a_link_active_ctrl_reset_one: assert property (@(posedge CLK)
        !NRST |=> link_active_ctrl_reg)
        else $error("link control not one after reset");

    a_link_active_ctrl_bus_reset: assert property (@(posedge CLK) disable iff (!NRST)
        (BUS_RESET_EVT && !wr5) |=> $stable(link_active_ctrl_reg))
        else $error("link control changed by bus reset");

    a_jitter_reads_zero: assert property (@(posedge CLK) disable iff (!NRST)
        (setup && in_range && idx == PBR_IDX_LINK_CONTENDER_POWER)
        |=> PRDATA[PBR_JIT_LSB +: 3] == 3'h0)
        else $error("jitter field not zero");

    a_short_reset_request_clears: assert property (@(posedge CLK) disable iff (!NRST)
        (BUS_RESET_EVT && !(wr6 && wdat[PBR_SHORT_RESET_REQUEST_BIT])) |=> !short_reset_request_reg)
        else $error("short reset request survived bus reset");

    a_short_to_long: assert property (@(posedge CLK) disable iff (!NRST)
        (short_reset_request_reg && LEGACY_NODE_PRESENT) |-> (LONG_RESET_REQ && !SHORT_RESET_REQ))
        else $error("short reset not converted with legacy node");

    a_cto_set_wins: assert property (@(posedge CLK) disable iff (!NRST)
        CONFIG_TIMEOUT_EVT |=> cto_reg)
        else $error("config timeout flag not set");

    a_linkon_drive: assert property (@(posedge CLK) disable iff (!NRST)
        (!link_active && resume_irq_enable_reg && (cto_reg || sto_reg)) |=> CONTENDER_LINKON_PIN_OE)
        else $error("linkon not driven for pending timeout");

    a_cable_power_irq_fall_sets: assert property (@(posedge CLK) disable iff (!NRST)
        ($fell(cps_sync_reg) ##1 1'b1) |-> cable_power_irq_reg)
        else $error("cable power fall did not set flag");

    a_sto_bus_reset: assert property (@(posedge CLK) disable iff (!NRST)
        STATE_TIMEOUT_EVT |=> (sto_reg && LONG_RESET_REQ))
        else $error("state timeout did not request bus reset");

    a_resume_pev: assert property (@(posedge CLK) disable iff (!NRST)
        (resume_irq_enable_reg && |RESUME_START_EVT) |=> pev_reg)
        else $error("resume start did not set port event flag");

    a_w0_keeps_flag: assert property (@(posedge CLK) disable iff (!NRST)
        (wr6 && !wdat[PBR_PEV_BIT] && pev_reg) |=> pev_reg)
        else $error("port event flag lost on zero write");

endmodule
`default_nettype wire

// *** pbr_regs_bench.sv ***
// Self-checking bench for the base control and status registers
`timescale 1ns/1ns
`default_nettype none
module pbr_regs_bench;
    import pbr_pkg::*;
    `define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
        $display("BAD %0t got %h want %h", $time, a, e); end end
    logic clk = 1'b0, nrst = 1'b0, link_power_status = 1'b1, ci = 1'b1, cable_power_sense = 1'b1, bre = 1'b0;
    logic cto = 1'b0, sto = 1'b0, lgc = 1'b0, prdy, perr, psel, pen, pwr;
    logic [2:0] pc = 3'h5;
    logic [2:0] rse = 3'h0, pfe = 3'h0;
    logic [7:0] pa;
    logic [31:0] pwd, prd, q;
    logic lo, loe, lie, sla, sre, lre;
    logic e;
    logic sic, aae, mce;
    logic [2:0] spc;
    pbr_port_stat_s pst [3] = '{default: '0};
    int fails = 0, checked = 0;
    pbr_regs u_pbr_regs (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(pa), .PWDATA(pwd), .PSTRB(4'hF), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
        .LINK_POWER_STATUS(link_power_status), .CONTENDER_LINKON_PIN_I(ci), .CONTENDER_LINKON_PIN_O(lo),
        .CONTENDER_LINKON_PIN_OE(loe), .POWER_CLASS_PINS(pc), .CABLE_POWER_SENSE(cable_power_sense),
        .BUS_RESET_EVT(bre), .CONFIG_TIMEOUT_EVT(cto), .STATE_TIMEOUT_EVT(sto),
        .LEGACY_NODE_PRESENT(lgc), .RESUME_START_EVT(rse), .PORT_FAULT_EVT(pfe),
        .PORT_STATUS(pst), .LINK_IF_ENABLE(lie), .SELF_ID_LINK_ACTIVE(sla),
        .SELF_ID_CONTENDER(sic), .SELF_ID_POWER_CLASS(spc), .SHORT_RESET_REQ(sre),
        .LONG_RESET_REQ(lre), .ACCEL_ARB_EN(aae), .MULTISPEED_CONCAT_EN(mce), .PORT_DISABLE(),
        .PAGE_SEL(), .PORT_SEL());
    pbr_llc_model u_pbr_llc_model (.clk(clk), .psel(psel), .penable(pen), .pwrite(pwr),
        .paddr(pa), .pwdata(pwd), .prdata(prd), .pready(prdy), .pslverr(perr));
    // --------------------------------
    // Clock, tasks and verdict
    // --------------------------------
    initial forever #5 clk = ~clk;
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_pbr_llc_model.xfer(1'b1, a, d, q, e);
    endtask
    // Read and compare; error flag expected only off the map
    task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
        u_pbr_llc_model.xfer(1'b0, a, 32'h0, q, e);
        `CHK(q, x)
        `CHK(e, xe)
    endtask
    task automatic print_verdict;
        $display("fails=%0d checked=%0d", fails, checked);
        if (fails == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog: after 3000 cycles, count a failure and end the run
    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        print_verdict();
    end
    // --------------------------------
    // Tests
    // --------------------------------
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rdc(8'h14, 32'hC5, 0);
        rdc(8'h18, 32'h10, 0);
        rdc(8'h1C, 32'h00, 0);
        wr(8'h14, 32'hFF);
        rdc(8'h14, 32'hC7, 0);
        `CHK(sla, 1'b1)
        `CHK({sic, spc}, 4'hF)
        wr(8'h14, 32'h00);
        // Let the write edge settle before looking at the outputs
        @(negedge clk);
        `CHK({sla, lie}, 2'b01)
        wr(8'h18, 32'h83);
        bre <= 1'b1;
        @(posedge clk) bre <= 1'b0;
        rdc(8'h18, 32'h93, 0);
        `CHK({aae, mce}, 2'b11)
        cto <= 1'b1;
        @(posedge clk) cto <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK({lo, loe}, 2'b11)
        rdc(8'h18, 32'hB3, 0);
        wr(8'h18, 32'hB0);
        rdc(8'h18, 32'h80, 0);
        lgc <= 1'b1;
        wr(8'h18, 32'hC0);
        @(negedge clk);
        `CHK({sre, lre}, 2'b01)
        @(posedge clk) bre <= 1'b1;
        @(posedge clk) bre <= 1'b0;
        rdc(8'h18, 32'h80, 0);
        sto <= 1'b1;
        @(posedge clk) sto <= 1'b0;
        cable_power_sense <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK(lre, 1'b1)
        rse <= 3'h4;
        @(posedge clk) rse <= 3'h0;
        rdc(8'h18, 32'h9C, 0);
        // Port 0 with its interrupt enabled, port event flag cleared first
        wr(8'h1C, 32'h00);
        wr(8'h24, 32'h10);
        wr(8'h18, 32'h84);
        pst[0].con <= 1'b1;
        @(posedge clk);
        rdc(8'h18, 32'h9C, 0);
        rdc(8'h20, 32'h04, 0);
        rdc(8'h24, 32'h10, 0);
        wr(8'h1C, 32'h0F);
        rdc(8'h20, 32'h00, 0);
        rdc(8'h1C, 32'h0F, 0);
        rdc(8'h40, 32'h00, 1);
        rdc(8'h00, 32'h00, 0);
        print_verdict();
    end
endmodule
`default_nettype wire
